// *** brc_consts.svh ***
// Constants for the burst read configuration block.
`ifndef BRC_CONSTS_SVH
`define BRC_CONSTS_SVH

// ==========================================================
// Command decoding
`define BRC_CODE_HI 19
`define BRC_CODE_LO 12
`define BRC_LOW_HI 11
`define BRC_CMD_CFG_DATA 8'hC0
`define BRC_CMD_CFG_ADDR 12'h555
`define BRC_UNLK1_ADDR 12'h555
`define BRC_UNLK1_DATA 8'hAA
`define BRC_UNLK2_ADDR 12'h2AA
`define BRC_UNLK2_DATA 8'h55

// ==========================================================
// Configuration defaults: asynchronous, ready with data,
// rising edge, continuous, latency code 101.
`define BRC_CFG_DEFAULT 8'hE5

// ==========================================================
// Latency and address pointer
`define BRC_WS_BASE 4'h2
`define BRC_ODD_EXTRA 4'h1
`define BRC_BND_EXTRA 4'h2
`define BRC_BND_NIB 4'hF
`define BRC_W8_MASK 6'h07
`define BRC_W16_MASK 6'h0F
`define BRC_W32_MASK 6'h1F

`endif

// *** brc_pkg.sv ***
// Types shared by the burst read configuration block.
package brc_pkg;

	// ==========================================================
	// Configuration word, laid out as address bits 19 down to 12.
	typedef enum logic [1:0] {BM_CONT, BM_WRAP8, BM_WRAP16, BM_WRAP32} brc_bmode_t;

	typedef struct packed {
		logic async_mode;
		logic rdy_with_data;
		logic edge_rise;
		brc_bmode_t burst_mode;
		logic [2:0] ws_code;
	} brc_cfg_t;

	// ==========================================================
	// Command side state.
	typedef enum logic [1:0] {U_IDLE, U_ONE, U_TWO} brc_ustep_t;

	typedef struct packed {
		brc_cfg_t cfg;
		brc_ustep_t step;
		logic tog;
	} brc_sys_t;

	// ==========================================================
	// Link side state.
	typedef enum logic [1:0] {L_IDLE, L_WAIT, L_BURST} brc_lst_t;

	typedef struct packed {
		logic [2:0] tsync;
		logic tlast;
		brc_cfg_t cfg;
		brc_lst_t st;
		logic [3:0] cnt;
		logic [3:0] target;
		logic [20:0] ptr;
		logic rdy;
		logic valid;
	} brc_link_t;

	// ==========================================================
	// Burst outputs towards the array and the ready pin.
	typedef struct packed {
		logic [20:0] addr;
		logic valid;
		logic rdy;
	} brc_burst_t;

endpackage

// *** brc_burst_cfg.sv ***
// Burst read configuration register and burst engine.
`timescale 1ns/1ns
`include "brc_consts.svh"

module brc_burst_cfg
	import brc_pkg::*;
#(
	parameter int ADDR_W = 21,
	parameter bit REDUCED_WS = 1'b0
) (
	input wire logic clock_in,
	input wire logic arst_n_in,
	input wire logic cmd_we_in,
	input wire logic [19:0] cmd_addr_in,
	input wire logic [7:0] cmd_data_in,
	input wire logic op_busy_in,
	output brc_cfg_t cfg_out,
	input wire logic link_clk_in,
	input wire logic address_valid_strobe_n_in,
	input wire logic [ADDR_W-1:0] addr_in,
	output logic [ADDR_W-1:0] burst_addr_out,
	output logic data_valid_out,
	output logic rdy_out
);

	// ==========================================================
	// Command side: unlock sequence and configuration register.
	brc_sys_t s_ff;
	brc_sys_t nxt_s;
	logic [11:0] low_addr;

	assign low_addr = cmd_addr_in[`BRC_LOW_HI:0];

	always_comb begin
		nxt_s = s_ff;
		if (cmd_we_in) begin
			nxt_s.step = U_IDLE;
			case (s_ff.step)
				U_IDLE: begin
					if (low_addr == `BRC_UNLK1_ADDR && cmd_data_in == `BRC_UNLK1_DATA) begin
						nxt_s.step = U_ONE;
					end
				end
				U_ONE: begin
					if (low_addr == `BRC_UNLK2_ADDR && cmd_data_in == `BRC_UNLK2_DATA) begin
						nxt_s.step = U_TWO;
					end
				end
				U_TWO: begin
					// A write during program or erase is dropped; any other configuration write
					// reaches the link side, which takes it even in the middle of a burst.
					if (low_addr == `BRC_CMD_CFG_ADDR && cmd_data_in == `BRC_CMD_CFG_DATA
						&& !op_busy_in) begin
						nxt_s.cfg = brc_cfg_t'(cmd_addr_in[`BRC_CODE_HI:`BRC_CODE_LO]);
						nxt_s.tog = !s_ff.tog;
					end
				end
				default: begin
					nxt_s.step = U_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			s_ff <= '{cfg: brc_cfg_t'(`BRC_CFG_DEFAULT), step: U_IDLE, tog: 1'b0};
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign cfg_out = s_ff.cfg;

	// ==========================================================
	// Link side clock. The polarity flips whenever a new word with a
	// different edge bit is taken, in any engine state; the extra edge
	// that makes can fall inside a running burst.
	brc_link_t l_ff;
	brc_link_t nxt_l;
	logic act_clk;

	assign act_clk = link_clk_in ^ !l_ff.cfg.edge_rise;

	// ==========================================================
	// Burst engine.
	logic [5:0] wmask6;
	logic [ADDR_W-1:0] wmask;
	logic [ADDR_W-1:0] ptr_inc;
	logic [3:0] tgt;

	always_comb begin
		case (l_ff.cfg.burst_mode)
			BM_WRAP8: wmask6 = `BRC_W8_MASK;
			BM_WRAP16: wmask6 = `BRC_W16_MASK;
			BM_WRAP32: wmask6 = `BRC_W32_MASK;
			default: wmask6 = 6'h00;
		endcase
		wmask = {{(ADDR_W-6){1'b0}}, wmask6};
		ptr_inc = l_ff.ptr + {{(ADDR_W-1){1'b0}}, 1'b1};
		tgt = {1'b0, l_ff.cfg.ws_code} + `BRC_WS_BASE;
		if (REDUCED_WS && addr_in[0]) begin
			tgt = tgt + `BRC_ODD_EXTRA;
		end
		if (REDUCED_WS && addr_in[5:2] == `BRC_BND_NIB) begin
			tgt = tgt + `BRC_BND_EXTRA;
		end
	end

	always_comb begin
		nxt_l = l_ff;
		nxt_l.tsync = {l_ff.tsync[1:0], s_ff.tog};
		if (l_ff.tsync[2] == l_ff.tsync[1] && l_ff.tsync[2] != l_ff.tlast) begin
			// The word has stood still since its toggle, so it is safe
			// to take as a whole.
			nxt_l.tlast = l_ff.tsync[2];
			nxt_l.cfg = s_ff.cfg;
		end
		if (!address_valid_strobe_n_in) begin
			nxt_l.ptr = addr_in;
			nxt_l.cnt = 4'h0;
			nxt_l.target = tgt;
			nxt_l.valid = 1'b0;
			if (l_ff.cfg.async_mode) begin
				nxt_l.st = L_IDLE;
				nxt_l.rdy = 1'b1;
			end else begin
				nxt_l.st = L_WAIT;
				nxt_l.rdy = 1'b0;
			end
		end else begin
			case (l_ff.st)
				L_WAIT: begin
					nxt_l.cnt = l_ff.cnt + 4'h1;
					if (nxt_l.cnt == l_ff.target) begin
						nxt_l.valid = 1'b1;
						nxt_l.rdy = 1'b1;
						nxt_l.st = L_BURST;
					end else if (nxt_l.cnt == l_ff.target - 4'h1 && !l_ff.cfg.rdy_with_data
						&& l_ff.cfg.ws_code != 3'h0) begin
						nxt_l.rdy = 1'b1;
					end
				end
				L_BURST: begin
					if (l_ff.cfg.burst_mode == BM_CONT) begin
						nxt_l.ptr = ptr_inc;
					end else begin
						nxt_l.ptr = (l_ff.ptr & ~wmask) | (ptr_inc & wmask);
					end
				end
				default: begin
					nxt_l.st = L_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge act_clk or negedge arst_n_in) begin
		if (!arst_n_in) begin
			l_ff <= '{tsync: 3'h0, tlast: 1'b0, cfg: brc_cfg_t'(`BRC_CFG_DEFAULT),
				st: L_IDLE, cnt: 4'h0, target: 4'h0, ptr: '0, rdy: 1'b1, valid: 1'b0};
		end else begin
			l_ff <= nxt_l;
		end
	end

	assign burst_addr_out = l_ff.ptr;
	assign data_valid_out = l_ff.valid;
	assign rdy_out = l_ff.rdy;

	// ==========================================================
	// Checks on the command side.
	AST_CFG_LOAD_CMD: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		!$stable(s_ff.cfg) |-> $past(cmd_we_in) && $past(cmd_data_in) == `BRC_CMD_CFG_DATA
			&& $past(s_ff.step) == U_TWO && !$past(op_busy_in))
		else $error("configuration changed without a valid third unlock cycle");

	AST_CFG_MODE_BIT: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		!$stable(s_ff.cfg) |-> s_ff.cfg.async_mode == $past(cmd_addr_in[19])
			&& s_ff.cfg.burst_mode == brc_bmode_t'($past(cmd_addr_in[16:15])))
		else $error("configuration fields not taken from the code bits");

	// ==========================================================
	// Checks on the link side.
	AST_LAT7: assert property (@(posedge act_clk) disable iff (!arst_n_in)
		(!address_valid_strobe_n_in && !l_ff.cfg.async_mode && !REDUCED_WS
			&& l_ff.cfg.ws_code == 3'h5) ##1 address_valid_strobe_n_in [*7] |=> l_ff.valid)
		else $error("first data not valid on the seventh edge");

	AST_LAT_EARLY: assert property (@(posedge act_clk) disable iff (!arst_n_in)
		(!address_valid_strobe_n_in && !l_ff.cfg.async_mode && !REDUCED_WS
			&& l_ff.cfg.ws_code == 3'h5) ##1 address_valid_strobe_n_in [*6] |=> !l_ff.valid)
		else $error("first data valid before the programmed edge");

	AST_LAT2: assert property (@(posedge act_clk) disable iff (!arst_n_in)
		(!address_valid_strobe_n_in && !l_ff.cfg.async_mode && !REDUCED_WS
			&& l_ff.cfg.ws_code == 3'h0) ##1 address_valid_strobe_n_in [*2] |=> l_ff.valid)
		else $error("latency code zero did not give data on the second edge");

	AST_RDY_CODE0: assert property (@(posedge act_clk) disable iff (!arst_n_in)
		(l_ff.st == L_WAIT && l_ff.cfg.ws_code == 3'h0) |-> !l_ff.rdy)
		else $error("ready ahead of data with latency code zero");

	AST_RDY_EARLY: assert property (@(posedge act_clk) disable iff (!arst_n_in)
		($rose(l_ff.valid) && !l_ff.cfg.rdy_with_data && l_ff.cfg.ws_code != 3'h0)
			|-> $past(l_ff.rdy) && !$past(l_ff.valid))
		else $error("ready not one cycle ahead of data");

	AST_RDY_WITH: assert property (@(posedge act_clk) disable iff (!arst_n_in)
		($rose(l_ff.rdy) && l_ff.cfg.rdy_with_data && !l_ff.cfg.async_mode
			&& address_valid_strobe_n_in) |-> l_ff.valid)
		else $error("ready rose without data");

	AST_CONT_INC: assert property (@(posedge act_clk) disable iff (!arst_n_in)
		(l_ff.st == L_BURST && $past(l_ff.st) == L_BURST && $past(address_valid_strobe_n_in)
			&& l_ff.cfg.burst_mode == BM_CONT) |-> l_ff.ptr == $past(l_ff.ptr) + 21'h1)
		else $error("continuous burst did not step by one");

	AST_WRAP_REGION: assert property (@(posedge act_clk) disable iff (!arst_n_in)
		(l_ff.st == L_BURST && $past(l_ff.st) == L_BURST && $past(address_valid_strobe_n_in)
			&& l_ff.cfg.burst_mode != BM_CONT) |-> l_ff.ptr[20:6] == $past(l_ff.ptr[20:6]))
		else $error("wrap burst left its 64-word region");

	AST_WRAP8_RETURN: assert property (@(posedge act_clk) disable iff (!arst_n_in)
		(l_ff.st == L_BURST && l_ff.cfg.burst_mode == BM_WRAP8 && address_valid_strobe_n_in)
			##1 (l_ff.st == L_BURST && address_valid_strobe_n_in) [*8]
			|-> l_ff.ptr == $past(l_ff.ptr, 8))
		else $error("eight-word wrap did not return to its start");

	COV_SYNC_BURST: cover property (@(posedge act_clk) disable iff (!arst_n_in)
		$rose(l_ff.valid) && !l_ff.cfg.async_mode);

	COV_WRAP_TURN: cover property (@(posedge act_clk) disable iff (!arst_n_in)
		l_ff.st == L_BURST && l_ff.cfg.burst_mode != BM_CONT && (l_ff.ptr & wmask) == '0);

	COV_RDY_EARLY: cover property (@(posedge act_clk) disable iff (!arst_n_in)
		l_ff.rdy && !l_ff.valid && l_ff.st == L_WAIT);

	COV_CFG_WRITE: cover property (@(posedge clock_in) disable iff (!arst_n_in)
		!$stable(s_ff.cfg));

endmodule

// *** brc_link_host.sv ***
// Host model that drives the burst clock, the address valid strobe and the start address.
`timescale 1ns/1ns
module brc_link_host (
	output logic link_clk_out,
	output logic address_valid_strobe_n_out,
	output logic [20:0] addr_out
);
	// ==========================================================
	// Idle state
	initial begin
		link_clk_out = 1'b0;
		address_valid_strobe_n_out = 1'b1;
		addr_out = 21'h0AAAAA;
	end

	// ==========================================================
	// Bus cycles
	// One clock period; the clock stands still low between calls, and the caller
	// samples after both edges so either active edge has landed.
	task automatic period();
		#80 link_clk_out = 1'b1;
		#80 link_clk_out = 1'b0;
		#2;
	endtask

	// The address is inverted while the strobe is high so that a stale value
	// is never taken for a valid one.
	task automatic drive(input logic strobe_n, input logic [20:0] addr);
		address_valid_strobe_n_out = strobe_n;
		addr_out = strobe_n ? ~addr_out : addr;
	endtask
endmodule

// *** brc_burst_cfg_tb.sv ***
// Self-checking testbench for the burst read configuration block.
`timescale 1ns/1ns
`include "brc_consts.svh"
module brc_burst_cfg_tb
	import brc_pkg::*;
;
	logic clock_in, arst_n_in, cmd_we_in, op_busy_in, lclk, strobe_n, valid, rdy;
	logic [19:0] cmd_addr_in;
	logic [7:0] cmd_data_in;
	logic [20:0] addr, burst_addr;
	brc_cfg_t cfg;
	int failures = 0;
	int cmp_count = 0;

	brc_burst_cfg brc_burst_cfg_inst (.clock_in(clock_in), .arst_n_in(arst_n_in),
		.cmd_we_in(cmd_we_in), .cmd_addr_in(cmd_addr_in), .cmd_data_in(cmd_data_in),
		.op_busy_in(op_busy_in), .cfg_out(cfg), .link_clk_in(lclk),
		.address_valid_strobe_n_in(strobe_n), .addr_in(addr),
		.burst_addr_out(burst_addr), .data_valid_out(valid), .rdy_out(rdy));
	brc_link_host brc_link_host_inst (.link_clk_out(lclk),
		.address_valid_strobe_n_out(strobe_n), .addr_out(addr));

	initial begin
		clock_in = 1'b0;
		forever #4 clock_in = ~clock_in;
	end

	// ==========================================================
	// Tasks
	task automatic chk(input string name, input logic [20:0] exp, input logic [20:0] got);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) begin
			brc_link_host_inst.drive(1'b1, 21'h0);
			brc_link_host_inst.period();
		end
	endtask

	task automatic wr(input logic [19:0] a, input logic [7:0] d);
		@(posedge clock_in);
		#1;
		cmd_we_in = 1'b1;
		cmd_addr_in = a;
		cmd_data_in = d;
	endtask

	// Codes 110 and 111 are never written because their latency is undefined.
	task automatic cmd(input logic [7:0] code, input logic [7:0] d3, input logic busy);
		op_busy_in = busy;
		wr({8'h00, `BRC_UNLK1_ADDR}, `BRC_UNLK1_DATA);
		wr({8'h00, `BRC_UNLK2_ADDR}, `BRC_UNLK2_DATA);
		wr({code, `BRC_CMD_CFG_ADDR}, d3);
		@(posedge clock_in);
		#1;
		cmd_we_in = 1'b0;
		op_busy_in = 1'b0;
		// The new word needs running link edges to reach the burst logic.
		idle(6);
	endtask

	task automatic burst(input logic [7:0] c, input logic [20:0] a, input int steps);
		int lat;
		logic [20:0] m;
		lat = int'(c[2:0]) + 2;
		m = (c[4:3] == 2'b00) ? 21'h1FFFFF : (21'h4 << c[4:3]) - 21'h1;
		brc_link_host_inst.drive(1'b0, a);
		brc_link_host_inst.period();
		chk("start pointer", a, burst_addr);
		chk("start ready", 21'(c[7]), 21'(rdy));
		for (int k = 1; k <= lat + steps; k++) begin
			brc_link_host_inst.drive(1'b1, a);
			brc_link_host_inst.period();
			chk("valid", 21'(k >= lat && !c[7]), 21'(valid));
			chk("ready", 21'(c[7] || k >= lat || (!c[6] && c[2:0] != 3'h0 && k == lat - 1)),
				21'(rdy));
			if (k >= lat && !c[7]) begin
				chk("pointer", (a & ~m) | ((a + 21'(k - lat)) & m), burst_addr);
			end
		end
	endtask

	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ==========================================================
	// Tests
	initial begin
		arst_n_in = 1'b0;
		cmd_we_in = 1'b0;
		op_busy_in = 1'b0;
		cmd_addr_in = 20'h00000;
		cmd_data_in = 8'h00;
		repeat (8) @(posedge clock_in);
		#1;
		arst_n_in = 1'b1;
		chk("reset config", 21'(`BRC_CFG_DEFAULT), 21'(cfg));
		chk("reset ready", 21'h1, 21'(rdy));
		burst(8'hE5, 21'h000123, 3);
		cmd(8'hE5, `BRC_CMD_CFG_DATA, 1'b0);
		cmd(8'h65, `BRC_CMD_CFG_DATA, 1'b0);
		chk("config", 21'h65, 21'(cfg));
		burst(8'h65, 21'h1FFFFC, 6);
		for (int i = 1; i < 4; i++) begin
			cmd({3'b001, 2'(i), 3'b000}, `BRC_CMD_CFG_DATA, 1'b0);
			burst({3'b001, 2'(i), 3'b000}, 21'h00003D, (4 << i) + 2);
		end
		cmd(8'h23, `BRC_CMD_CFG_DATA, 1'b0);
		burst(8'h23, 21'h000042, 3);
		cmd(8'h44, `BRC_CMD_CFG_DATA, 1'b0);
		burst(8'h44, 21'h000010, 3);
		cmd(8'h65, `BRC_CMD_CFG_DATA, 1'b1);
		chk("busy write", 21'h44, 21'(cfg));
		cmd(8'h65, 8'hA0, 1'b0);
		chk("bad data write", 21'h44, 21'(cfg));
		cmd(`BRC_CFG_DEFAULT, `BRC_CMD_CFG_DATA, 1'b0);
		burst(8'hE5, 21'h000321, 2);
		final_report();
	end

	initial begin
		#400000;
		failures++;
		final_report();
	end
endmodule
